// ---- dv/sensor_frame_model.sv ----
// behavioural sensor interface: frame starts and engine completion pulses
`timescale 1ns/100ps
module sensor_frame_model (
   input  wire logic       clk,
   input  wire logic       rst_n,
   input  wire logic       go,
   input  wire logic [7:0] focus_gap,
   input  wire logic [7:0] expo_gap,
   output logic            frame_start,
   output logic            focus_done,
   output logic            expo_done
);
   // ==========================================================
   // frame timing
   logic [7:0] cnt;

   // counter parks at its top value: no done pulse outside a frame
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt         <= 8'hFF;
         frame_start <= 1'b0;
         focus_done  <= 1'b0;
         expo_done   <= 1'b0;
      end else begin
         frame_start <= go;
         cnt         <= go ? 8'h00 : ((cnt == 8'hFF) ? cnt : cnt + 8'h01);
         focus_done  <= (cnt == focus_gap) && (cnt != 8'hFF);
         expo_done   <= (cnt == expo_gap) && (cnt != 8'hFF);
      end
   end
endmodule

// ---- dv/test_image_statistics_engine_control.sv ----
// self-checking bench for the image statistics control shell
`timescale 1ns/100ps
module test_image_statistics_engine_control;
   import stats_pkg::*;
   typedef struct packed {addr_t a; word_t d; word_t e;} row_s;
   logic        CLK_SYS, RST_N, REG_WR, REG_RD, go;
   addr_t       REG_ADDR;
   word_t       REG_WDATA, rv;
   logic [31:0] REG_RDATA, FOCUS_BASE, EXPOSURE_BASE, FOCUS_COEF, LINE_START;
   logic        FRAME_START, FOCUS_DONE, EXPOSURE_DONE, FOCUS_RUN, EXPOSURE_RUN;
   logic        FOCUS_VERTICAL, FOCUS_DONE_IRQ, EXPOSURE_DONE_IRQ, FRAME_DONE_IRQ;
   shadow_arr_t SHADOW_WORK;
   logic [7:0]  focus_gap, expo_gap;
   int          err_total, checks_done, n_fdi, n_edi, n_frd;
   row_s        rows [8] = '{'{8'h04, 32'h01234567, 32'h01234567},
                             '{8'h24, 32'h89ABCDEF, 32'h89ABCDEF},
                             '{8'h28, 32'hFFFFFFFF, 32'hFFFFFFC0},
                             '{8'h2C, 32'h1234567F, 32'h12345640},
                             '{8'h30, 32'hA5A5A5A5, 32'hA5A5A5A5},
                             '{8'h34, 32'h00000FFF, 32'h00000FFF},
                             '{8'h40, 32'hDEADBEEF, 32'h00000000},
                             '{8'h00, 32'hFFFFFFFF, 32'h00000007}};

   image_statistics_block DUT (
      .CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
      .FRAME_START(FRAME_START), .FOCUS_DONE(FOCUS_DONE), .EXPOSURE_DONE(EXPOSURE_DONE),
      .FOCUS_RUN(FOCUS_RUN), .EXPOSURE_RUN(EXPOSURE_RUN), .FOCUS_VERTICAL(FOCUS_VERTICAL),
      .FOCUS_BASE(FOCUS_BASE), .EXPOSURE_BASE(EXPOSURE_BASE), .FOCUS_COEF(FOCUS_COEF),
      .LINE_START(LINE_START), .SHADOW_WORK(SHADOW_WORK),
      .FOCUS_DONE_IRQ(FOCUS_DONE_IRQ), .EXPOSURE_DONE_IRQ(EXPOSURE_DONE_IRQ),
      .FRAME_DONE_IRQ(FRAME_DONE_IRQ)
   );

   sensor_frame_model sensor (
      .clk(CLK_SYS), .rst_n(RST_N), .go(go), .focus_gap(focus_gap),
      .expo_gap(expo_gap), .frame_start(FRAME_START), .focus_done(FOCUS_DONE),
      .expo_done(EXPOSURE_DONE)
   );

   // ==========================================================
   // clock and done-pulse counting
   initial begin
      CLK_SYS = 1'b0;
      forever #4 CLK_SYS = ~CLK_SYS;
   end

   // pulses are one cycle, so one sample per edge counts each once
   always @(posedge CLK_SYS) begin
      if (FOCUS_DONE_IRQ === 1'b1) n_fdi++;
      if (EXPOSURE_DONE_IRQ === 1'b1) n_edi++;
      if (FRAME_DONE_IRQ === 1'b1) n_frd++;
   end

   // ==========================================================
   // helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge CLK_SYS);
      #1;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input addr_t a, input word_t d);
      @(posedge CLK_SYS);
      REG_WR    <= 1'b1;
      REG_ADDR  <= a;
      REG_WDATA <= d;
      @(posedge CLK_SYS);
      REG_WR    <= 1'b0;
      #1;
   endtask

   task automatic rd(input addr_t a);
      @(posedge CLK_SYS);
      REG_RD   <= 1'b1;
      REG_ADDR <= a;
      @(posedge CLK_SYS);
      REG_RD   <= 1'b0;
      #1 rv = REG_RDATA;
   endtask

   task automatic frame();
      @(posedge CLK_SYS);
      go <= 1'b1;
      @(posedge CLK_SYS);
      go <= 1'b0;
      cyc(2);
   endtask

   task automatic wait_idle();
      int k;
      k = 0;
      while ((FOCUS_RUN !== 1'b0 || EXPOSURE_RUN !== 1'b0) && k < 300) begin
         cyc(1);
         k++;
      end
      chk(32'(k >= 300), 32'h0);
      cyc(2);
   endtask

   task automatic chk_rst();
      for (int a = 0; a <= 'h34; a += 4) begin
         rd(addr_t'(a));
         chk(rv, WORD_RST);
      end
      chk(32'({FOCUS_RUN, EXPOSURE_RUN, FOCUS_VERTICAL}), 32'h0);
      chk(SHADOW_WORK[0] | SHADOW_WORK[8] | FOCUS_BASE | LINE_START, 32'h0);
   endtask

   function automatic logic [31:0] irqs();
      return 32'(n_fdi * 256 + n_edi * 16 + n_frd);
   endfunction

   task automatic end_sim();
      if (err_total == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ==========================================================
   // main sequence
   initial begin
      RST_N = 1'b0;
      REG_WR = 1'b0;
      REG_RD = 1'b0;
      REG_ADDR = 8'h00;
      REG_WDATA = 32'h00000000;
      go = 1'b0;
      focus_gap = 8'd40;
      expo_gap = 8'd70;
      repeat (16) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      cyc(1);
      chk_rst();
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a);
         chk(rv, rows[i].e);
      end
      chk(FOCUS_BASE, 32'hFFFFFFC0);
      chk(EXPOSURE_BASE, 32'h12345640);
      chk(FOCUS_COEF, 32'hA5A5A5A5);
      chk(LINE_START, 32'h00000FFF);
      // back-to-back shadow write then read of the same word
      @(posedge CLK_SYS);
      REG_WR    <= 1'b1;
      REG_ADDR  <= OFS_SHADOW_LAST;
      REG_WDATA <= 32'h600DF00D;
      @(posedge CLK_SYS);
      REG_WR    <= 1'b0;
      REG_RD    <= 1'b1;
      @(posedge CLK_SYS);
      REG_RD    <= 1'b0;
      #1;
      chk(REG_RDATA, 32'h600DF00D);
      // whole shadow set: pending until a frame starts
      wr(OFS_CTRL, WORD_RST);
      // geometry words stand in for legal, even, adjacent regions
      for (int i = 0; i < NUM_SHADOW; i++) begin
         wr(OFS_SHADOW_FIRST + addr_t'(4 * i), 32'h5A5A0000 | word_t'(i));
         chk(SHADOW_WORK[i], 32'h0);
      end
      frame();
      for (int i = 0; i < NUM_SHADOW; i++) begin
         chk(SHADOW_WORK[i], 32'h5A5A0000 | word_t'(i));
      end
      // focus only, slow engine; lock, shadow and late disable in mid-frame
      wr(OFS_CTRL, 32'h00000001);
      frame();
      chk(32'({FOCUS_RUN, EXPOSURE_RUN}), 32'h2);
      rd(OFS_CTRL);
      chk(rv, 32'h00000101);
      wr(OFS_FOCUS_BASE, 32'h00001000);
      chk(FOCUS_BASE, 32'hFFFFFFC0);
      wr(OFS_SHADOW_FIRST, 32'hC0DE0001);
      rd(OFS_SHADOW_FIRST);
      chk(rv, 32'hC0DE0001);
      chk(SHADOW_WORK[0], 32'h5A5A0000);
      wr(OFS_CTRL, WORD_RST);
      chk(32'(FOCUS_RUN), 32'h1);
      wait_idle();
      chk(irqs(), 32'h101);
      wr(OFS_FOCUS_BASE, 32'h00001000);
      chk(FOCUS_BASE, 32'h00001000);
      frame();
      chk(32'({FOCUS_RUN, EXPOSURE_RUN}), 32'h0);
      chk(SHADOW_WORK[0], 32'hC0DE0001);
      // stray completions while idle must raise nothing
      cyc(80);
      chk(irqs(), 32'h101);
      // both engines, prompt answers, vertical mode
      focus_gap <= 8'd3;
      expo_gap <= 8'd6;
      wr(OFS_CTRL, 32'h00000007);
      frame();
      chk(32'({FOCUS_RUN, EXPOSURE_RUN, FOCUS_VERTICAL}), 32'h7);
      wait_idle();
      chk(irqs(), 32'h212);
      wr(OFS_CTRL, 32'h00000002);
      frame();
      // working vertical mode only moves at a focus frame start, so it keeps 1
      chk(32'({FOCUS_RUN, EXPOSURE_RUN, FOCUS_VERTICAL}), 32'h3);
      wait_idle();
      chk(irqs(), 32'h223);
      // reset in mid-frame
      focus_gap <= 8'd40;
      wr(OFS_CTRL, 32'h00000001);
      frame();
      RST_N <= 1'b0;
      cyc(1);
      chk(32'({FOCUS_RUN, FOCUS_DONE_IRQ}), 32'h0);
      repeat (3) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      cyc(1);
      chk_rst();
      end_sim();
   end

   // ==========================================================
   // watchdog: whole sequence needs under 3000 cycles
   initial begin
      err_total = 0;
      checks_done = 0;
      n_fdi = 0;
      n_edi = 0;
      n_frd = 0;
      repeat (20000) @(posedge CLK_SYS);
      err_total++;
      end_sim();
   end
endmodule

// ---- hw/image_statistics_block.sv ----
// control shell of the image statistics block: registers, busy flags, done pulses
`timescale 1ns/100ps
module image_statistics_block (
   input  wire logic                CLK_SYS,
   input  wire logic                RST_N,
   input  wire stats_pkg::addr_t    REG_ADDR,
   input  wire stats_pkg::word_t    REG_WDATA,
   input  wire logic                REG_WR,
   input  wire logic                REG_RD,
   output logic [31:0]              REG_RDATA,
   input  wire logic                FRAME_START,
   input  wire logic                FOCUS_DONE,
   input  wire logic                EXPOSURE_DONE,
   output logic                     FOCUS_RUN,
   output logic                     EXPOSURE_RUN,
   output logic                     FOCUS_VERTICAL,
   output logic [31:0]              FOCUS_BASE,
   output logic [31:0]              EXPOSURE_BASE,
   output logic [31:0]              FOCUS_COEF,
   output logic [31:0]              LINE_START,
   output stats_pkg::shadow_arr_t   SHADOW_WORK,
   output logic                     FOCUS_DONE_IRQ,
   output logic                     EXPOSURE_DONE_IRQ,
   output logic                     FRAME_DONE_IRQ
);
   import stats_pkg::*;

   // ==========================================================
   // state
   typedef struct packed {
      logic  focus_en;
      logic  expo_en;
      logic  vf_en;
      logic  focus_busy;
      logic  expo_busy;
      logic  vf_work;
      word_t focus_base;
      word_t expo_base;
      word_t focus_coef;
      word_t line_start;
      word_t rdata;
      logic  focus_irq;
      logic  expo_irq;
      logic  frame_irq;
   } ctrl_state_s;

   ctrl_state_s s_reg;
   ctrl_state_s s_next;

   logic any_busy;
   logic focus_fin;
   logic expo_fin;
   logic shadow_hit;

   stats_shadow_if sh ();

   // ==========================================================
   // shadow bank
   assign shadow_hit = is_shadow(REG_ADDR);
   assign sh.wr      = REG_WR && shadow_hit;
   assign sh.idx     = shadow_idx(REG_ADDR);
   assign sh.wdata   = REG_WDATA;
   assign sh.sof     = FRAME_START;

   stats_shadow_bank u_bank (
      .CLK_SYS (CLK_SYS),
      .RST_N   (RST_N),
      .sh      (sh.bank)
   );

   // ==========================================================
   // engine status
   assign any_busy  = s_reg.focus_busy || s_reg.expo_busy;
   assign focus_fin = s_reg.focus_busy && FOCUS_DONE;
   assign expo_fin  = s_reg.expo_busy && EXPOSURE_DONE;

   // ==========================================================
   // next state
   always_comb begin
      s_next           = s_reg;
      s_next.focus_irq = 1'b0;
      s_next.expo_irq  = 1'b0;
      s_next.frame_irq = 1'b0;
      s_next.rdata     = WORD_RST;

      // enable bits stay writable while busy so a running engine can be
      // told to stop; the stop only bites at the next frame start
      if (REG_WR && (REG_ADDR == OFS_CTRL)) begin
         s_next.focus_en = REG_WDATA[CTRL_FOCUS_EN_BIT];
         s_next.expo_en  = REG_WDATA[CTRL_EXPO_EN_BIT];
         s_next.vf_en    = REG_WDATA[CTRL_VF_EN_BIT];
      end

      // busy-lock: accepted on the bus, dropped in hardware
      if (REG_WR && !any_busy) begin
         unique case (REG_ADDR)
            OFS_FOCUS_BASE: begin
               s_next.focus_base = REG_WDATA & BASE_MASK;
            end
            OFS_EXPO_BASE: begin
               s_next.expo_base = REG_WDATA & BASE_MASK;
            end
            OFS_FOCUS_COEF: begin
               s_next.focus_coef = REG_WDATA;
            end
            OFS_LINE_START: begin
               s_next.line_start = REG_WDATA;
            end
            default: begin
            end
         endcase
      end

      // engine completion
      if (focus_fin) begin
         s_next.focus_busy = 1'b0;
         s_next.focus_irq  = 1'b1;
      end
      if (expo_fin) begin
         s_next.expo_busy = 1'b0;
         s_next.expo_irq  = 1'b1;
      end
      // the last engine of the frame to finish raises the frame pulse
      if ((focus_fin || expo_fin)
          && (!s_reg.focus_busy || focus_fin)
          && (!s_reg.expo_busy || expo_fin)) begin
         s_next.frame_irq = 1'b1;
      end

      // frame start samples the enables; set wins over a same-cycle finish.
      // an engine enabled mid-frame therefore idles until the next frame
      if (FRAME_START) begin
         if (s_reg.focus_en) begin
            s_next.focus_busy = 1'b1;
            s_next.vf_work    = s_reg.vf_en;
         end
         if (s_reg.expo_en) begin
            s_next.expo_busy = 1'b1;
         end
      end

      // read data, valid the cycle after the strobe only
      if (REG_RD) begin
         if (shadow_hit) begin
            s_next.rdata = sh.pend[sh.idx];
         end else begin
            unique case (REG_ADDR)
               OFS_CTRL: begin
                  s_next.rdata[CTRL_FOCUS_EN_BIT]   = s_reg.focus_en;
                  s_next.rdata[CTRL_EXPO_EN_BIT]    = s_reg.expo_en;
                  s_next.rdata[CTRL_VF_EN_BIT]      = s_reg.vf_en;
                  s_next.rdata[CTRL_FOCUS_BUSY_BIT] = s_reg.focus_busy;
                  s_next.rdata[CTRL_EXPO_BUSY_BIT]  = s_reg.expo_busy;
               end
               OFS_FOCUS_BASE: begin
                  s_next.rdata = s_reg.focus_base;
               end
               OFS_EXPO_BASE: begin
                  s_next.rdata = s_reg.expo_base;
               end
               OFS_FOCUS_COEF: begin
                  s_next.rdata = s_reg.focus_coef;
               end
               OFS_LINE_START: begin
                  s_next.rdata = s_reg.line_start;
               end
               default: begin
                  s_next.rdata = WORD_RST;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // registers
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // ==========================================================
   // outputs
   assign REG_RDATA         = s_reg.rdata;
   assign FOCUS_RUN         = s_reg.focus_busy;
   assign EXPOSURE_RUN      = s_reg.expo_busy;
   assign FOCUS_VERTICAL    = s_reg.vf_work;
   assign FOCUS_BASE        = s_reg.focus_base;
   assign EXPOSURE_BASE     = s_reg.expo_base;
   assign FOCUS_COEF        = s_reg.focus_coef;
   assign LINE_START        = s_reg.line_start;
   assign SHADOW_WORK       = sh.work;
   assign FOCUS_DONE_IRQ    = s_reg.focus_irq;
   assign EXPOSURE_DONE_IRQ = s_reg.expo_irq;
   assign FRAME_DONE_IRQ    = s_reg.frame_irq;

   // ==========================================================
   // checks
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   sequence seq_shadow_write;
      REG_WR && shadow_hit;
   endsequence

   sequence seq_same_read;
      REG_RD && !REG_WR && (REG_ADDR == $past(REG_ADDR));
   endsequence

   sequence seq_focus_start;
      FRAME_START && s_reg.focus_en;
   endsequence

   property p_start_sets_busy;
      seq_focus_start |=> FOCUS_RUN && (FOCUS_VERTICAL == $past(s_reg.vf_en));
   endproperty

   AST_FOCUS_BUSY_SET: assert property (p_start_sets_busy)
      else $error("focus busy not set at frame start");

   AST_EXPO_BUSY_SET: assert property (
      FRAME_START && s_reg.expo_en |=> EXPOSURE_RUN)
      else $error("exposure busy not set at frame start");

   AST_NO_START_IDLE: assert property (
      !FOCUS_RUN && !FRAME_START |=> !FOCUS_RUN)
      else $error("focus engine started outside frame start");

   AST_FOCUS_BUSY_CLR: assert property (
      FOCUS_RUN && FOCUS_DONE && !FRAME_START |=> !FOCUS_RUN ##1 !FOCUS_DONE_IRQ)
      else $error("focus busy not cleared on finish");

   AST_HOLD_TO_EOF: assert property (
      FOCUS_RUN && !FOCUS_DONE |=> FOCUS_RUN)
      else $error("focus engine stopped mid-frame");

   AST_EXPO_BUSY_CLR: assert property (
      EXPOSURE_RUN && EXPOSURE_DONE && !FRAME_START |=> !EXPOSURE_RUN)
      else $error("exposure busy not cleared on finish");

   AST_FOCUS_IRQ_CAUSE: assert property (
      FOCUS_DONE_IRQ |-> $past(FOCUS_RUN && FOCUS_DONE))
      else $error("focus done pulse without cause");

   AST_EXPO_IRQ: assert property (
      EXPOSURE_RUN && EXPOSURE_DONE |=> EXPOSURE_DONE_IRQ)
      else $error("exposure done pulse missing");

   AST_FRAME_IRQ: assert property (
      FRAME_DONE_IRQ |-> $past(any_busy) && !($past(FOCUS_RUN) && !$past(FOCUS_DONE))
                         && !($past(EXPOSURE_RUN) && !$past(EXPOSURE_DONE)))
      else $error("frame done pulse while an engine still runs");

   AST_LOCKED_WRITE: assert property (
      REG_WR && (REG_ADDR == OFS_FOCUS_BASE) && any_busy |=> $stable(FOCUS_BASE))
      else $error("busy-locked register changed while busy");

   AST_OPEN_WRITE: assert property (
      REG_WR && (REG_ADDR == OFS_EXPO_BASE) && !any_busy
      |=> EXPOSURE_BASE == ($past(REG_WDATA) & BASE_MASK))
      else $error("idle write to base register lost");

   AST_SHADOW_READBACK: assert property (
      seq_shadow_write ##1 seq_same_read |=> REG_RDATA == $past(REG_WDATA, 2))
      else $error("shadow read does not return last write");

   AST_SHADOW_COMMIT: assert property (
      !FRAME_START |=> $stable(SHADOW_WORK))
      else $error("working shadow copy changed outside frame start");

   AST_READ_ONE_CYCLE: assert property (
      !REG_RD |=> REG_RDATA == WORD_RST)
      else $error("read data present without a read");

endmodule

// ---- hw/stats_pkg.sv ----
// constants, types and decode helpers for the image statistics control block
// What this block does
// - subsystem reset returns every statistics register to its reset value
// - focus and exposure engines each have their own enable bit
// - focus enable starts focus engine, exposure enable starts exposure engine
// - enable engines before the sensor interface; engines wait for next frame
// - clearing an enable mid-frame takes effect only at end of that frame
// - three done pulses: focus, exposure, and whichever enabled engine finishes last
// - start of frame sets each busy flag whose engine enable is set
// - each busy flag clears to 0 when its engine finishes the frame
// - shadow registers take writes anytime; copied to working set at frame start
// - reading a shadow register returns the latest written value
// - shadowed set is focus region, filter start and exposure window registers
// - while busy, writes to non-shadow registers other than control complete but change nothing
// - base, coefficient and line start registers are busy-locked and writable again once idle
// - vertical focus enable 0 gives horizontal only, 1 adds vertical values
package stats_pkg;

   // ==========================================================
   // widths
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 32;
   localparam int NUM_SHADOW = 9;
   localparam int IDX_W      = 4;

   typedef logic [ADDR_W-1:0]                  addr_t;
   typedef logic [DATA_W-1:0]                  word_t;
   typedef logic [IDX_W-1:0]                   idx_t;
   typedef logic [NUM_SHADOW-1:0][DATA_W-1:0]  shadow_arr_t;

   // ==========================================================
   // register offsets (byte addresses)
   localparam addr_t OFS_CTRL         = 8'h00;
   localparam addr_t OFS_SHADOW_FIRST = 8'h04;
   localparam addr_t OFS_SHADOW_LAST  = 8'h24;
   localparam addr_t OFS_FOCUS_BASE   = 8'h28;
   localparam addr_t OFS_EXPO_BASE    = 8'h2C;
   localparam addr_t OFS_FOCUS_COEF   = 8'h30;
   localparam addr_t OFS_LINE_START   = 8'h34;

   // shadow order: focus size a/b, focus start, filter hstart,
   // exposure size, start, black row, subsample, output config
   localparam int WORD_SHIFT = 2;

   // ==========================================================
   // control register fields
   localparam int CTRL_FOCUS_EN_BIT   = 0;
   localparam int CTRL_EXPO_EN_BIT    = 1;
   localparam int CTRL_VF_EN_BIT      = 2;
   localparam int CTRL_FOCUS_BUSY_BIT = 8;
   localparam int CTRL_EXPO_BUSY_BIT  = 9;

   // base addresses ignore the bits below a 64-byte boundary
   localparam int    BASE_ALIGN_BITS = 6;
   localparam word_t BASE_MASK       = 32'hFFFFFFC0;

   // ==========================================================
   // reset values
   localparam word_t WORD_RST   = 32'h00000000;
   localparam logic  BIT_RST    = 1'b0;

   // ==========================================================
   // decode helpers
   function automatic logic is_shadow(input addr_t a);
      return (a >= OFS_SHADOW_FIRST) && (a <= OFS_SHADOW_LAST) && (a[1:0] == 2'h0);
   endfunction

   function automatic idx_t shadow_idx(input addr_t a);
      addr_t d;
      d = a - OFS_SHADOW_FIRST;
      return d[IDX_W+WORD_SHIFT-1:WORD_SHIFT];
   endfunction

endpackage

// ---- hw/stats_shadow_bank.sv ----
// pending and working copies of the shadowed configuration registers
`timescale 1ns/100ps
module stats_shadow_bank (
   input  wire logic       CLK_SYS,
   input  wire logic       RST_N,
   stats_shadow_if.bank    sh
);
   import stats_pkg::*;

   typedef struct packed {
      shadow_arr_t pend;
      shadow_arr_t work;
   } bank_state_s;

   bank_state_s st_reg;
   bank_state_s st_next;

   // ==========================================================
   // next state
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < NUM_SHADOW; i++) begin
         if (sh.wr && (sh.idx == idx_t'(i))) begin
            st_next.pend[i] = sh.wdata;
         end
      end
      // a write in the frame-start cycle still lands in this frame
      if (sh.sof) begin
         st_next.work = st_next.pend;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sh.pend = st_reg.pend;
   assign sh.work = st_reg.work;
endmodule

// ---- hw/stats_shadow_if.sv ----
// link between the control shell and the shadow register bank
`timescale 1ns/100ps
interface stats_shadow_if;
   import stats_pkg::*;
   logic        wr;
   idx_t        idx;
   word_t       wdata;
   logic        sof;
   shadow_arr_t pend;
   shadow_arr_t work;

   modport ctrl (output wr, output idx, output wdata, output sof,
                 input pend, input work);
   modport bank (input wr, input idx, input wdata, input sof,
                 output pend, output work);
endinterface
